// [common/aci_regs.svh]
`ifndef ACI_REGS_SVH
`define ACI_REGS_SVH

// ==========================================================
// register offsets (byte addresses)
`define ACI_OFF_CTRL 8'h00
`define ACI_OFF_SCALE 8'h04
`define ACI_OFF_THRESH 8'h08
`define ACI_OFF_SUBST 8'h0c
`define ACI_OFF_SIM 8'h10
`define ACI_OFF_LIMIT 8'h14
`define ACI_OFF_STATUS 8'h18
`define ACI_OFF_TLG 8'h1c

// ==========================================================
// control register fields
`define ACI_CTRL_WSTAT 0
`define ACI_CTRL_LFD 1
`define ACI_CTRL_SIM 2
`define ACI_CTRL_EMODE_LO 3
`define ACI_CTRL_EMODE_HI 4
`define ACI_CTRL_DIAG 5
`define ACI_CTRL_HART 6
`define ACI_CTRL_HVARS_LO 8
`define ACI_CTRL_HVARS_HI 10

// error mode codes
`define ACI_EMODE_CURRENT 2'h0
`define ACI_EMODE_SUBST 2'h1
`define ACI_EMODE_LAST 2'h2

// ==========================================================
// reset values
`define ACI_RST_WSTAT 1'h1
`define ACI_RST_LFD 1'h1
`define ACI_RST_DIAG 1'h1
`define ACI_RST_HART 1'h1
`define ACI_RST_START 16'h2710
`define ACI_RST_END 16'hc350
`define ACI_RST_VMIN 16'h0000
`define ACI_RST_VMAX 16'hffff
`define ACI_RST_SUBST 16'h0000
`define ACI_RST_SIM 16'h0000

// ==========================================================
// current scale: one converter step in nA, loop points in uA
`define ACI_LSB_NA 6400
`define ACI_SPAN_STEPS 2500
`define ACI_ZERO_UA 4000
`define ACI_LIVE_ZERO_UA 3600
`define ACI_BREAK_UA 1000
`define ACI_SHORT_UA 21000
`define ACI_UA_TO_RAW(ua) ((ua) * 1000 / `ACI_LSB_NA)

// ==========================================================
// configuration codes
`define ACI_CFG_BASE 8'h50
`define ACI_CFG_STEP 8'h02
`define ACI_HVARS_MAX 3'h4

// ==========================================================
// timing
`define ACI_CLK_HZ 10000000
`define ACI_CONV_MS 100
`define ACI_SEND_US 6500
`define ACI_CONV_CYCLES (`ACI_CLK_HZ / 1000 * `ACI_CONV_MS)
`define ACI_SEND_CYCLES (`ACI_CLK_HZ / 1000000 * `ACI_SEND_US)

`endif

// [common/aci_pkg.sv]
`include "aci_regs.svh"

package aci_pkg;

   // ==========================================================
   // conversion sequencer
   typedef enum logic [0:0] {
      CONV_WAIT,
      CONV_BUSY
   } aci_conv_type;

   // ==========================================================
   // whole state of the input channel
   typedef struct packed {
      logic with_status;
      logic lfd_en;
      logic sim_mode;
      logic [1:0] err_mode;
      logic diag_en;
      logic hart_en;
      logic [2:0] hart_vars;
      logic [15:0] scale_start;
      logic [15:0] scale_end;
      logic [11:0] brk_thr;
      logic [11:0] sht_thr;
      logic [15:0] subst;
      logic [15:0] simval;
      logic [15:0] vmin;
      logic [15:0] vmax;
      aci_conv_type conv_st;
      logic [19:0] conv_cnt;
      logic [16:0] send_cnt;
      logic conv_start;
      logic new_meas;
      logic [11:0] raw;
      logic live_zero;
      logic brk;
      logic sht;
      logic fault;
      logic [15:0] last_valid;
      logic [15:0] value;
      logic [15:0] tlg_word;
      logic tlg_valid;
      logic [7:0] cfg_code;
      logic mod_err;
      logic glob_err;
      logic chan_err;
      logic [1:0] err_reason;
      logic dph_valid;
      logic dph_write;
      logic [7:0] dph_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic [7:0] err_slot;
      logic [3:0] err_chan;
      logic err_is_input;
   } aci_state_type;

endpackage

// [hdl/aci_scaler.sv]
`timescale 1ns/1ps
`default_nettype none
`include "aci_regs.svh"

module aci_scaler (
   input wire logic [11:0] raw,
   input wire logic [15:0] range_start,
   input wire logic [15:0] range_end,
   input wire logic [15:0] vmin,
   input wire logic [15:0] vmax,
   output logic [15:0] value
);

   // ==========================================================
   // linear map of steps above the 4 mA zero onto start..end
   localparam logic signed [13:0] ZERO_RAW = 14'(`ACI_UA_TO_RAW(`ACI_ZERO_UA));
   localparam logic signed [31:0] STEPS = 32'(`ACI_SPAN_STEPS);

   logic signed [13:0] pct;
   logic signed [17:0] span;
   logic signed [31:0] prod;
   logic signed [31:0] quo;
   logic signed [31:0] sum;

   always_comb begin
      pct = $signed({2'h0, raw}) - ZERO_RAW;
      span = $signed({2'h0, range_end}) - $signed({2'h0, range_start});
      prod = 32'(pct * span);
      quo = prod / STEPS;
      sum = quo + $signed({16'h0000, range_start});
      if (sum < $signed({16'h0000, vmin})) begin
         value = vmin;
      end else if (sum > $signed({16'h0000, vmax})) begin
         value = vmax;
      end else begin
         value = sum[15:0];
      end
   end

endmodule

`default_nettype wire

// [hdl/aci_top.sv]
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "aci_regs.svh"

module aci_top #(
   parameter int unsigned CONV_CYCLES = `ACI_CONV_CYCLES,
   parameter int unsigned SEND_CYCLES = `ACI_SEND_CYCLES,
   parameter logic [7:0] SLOT = 8'h00,
   parameter logic [3:0] CHANNEL = 4'h1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic conv_start,
   input wire logic adc_valid,
   input wire logic [11:0] adc_data,
   output logic [15:0] tlg_word,
   output logic tlg_valid,
   output logic [7:0] cfg_code,
   output logic hart_en,
   output logic mod_err,
   output logic glob_err,
   output logic chan_err,
   output logic [7:0] chan_err_slot,
   output logic [3:0] chan_err_chan,
   output logic chan_err_is_input,
   output logic [1:0] chan_err_reason
);

   // ==========================================================
   // state
   aci_pkg::aci_state_type s_q;
   aci_pkg::aci_state_type s_d;
   logic [15:0] scaled;
   logic [15:0] base_val;
   logic [15:0] sel_val;
   logic [15:0] word;
   logic default_scale;
   logic live_zero_now;
   logic brk_now;
   logic sht_now;
   logic fault_now;
   logic addr_phase;
   logic [2:0] vars_clamped;

   localparam logic [19:0] CONV_LAST = 20'(CONV_CYCLES - 1);
   localparam logic [16:0] SEND_LAST = 17'(SEND_CYCLES - 1);
   localparam logic [11:0] LIVE_ZERO_RAW = 12'(`ACI_UA_TO_RAW(`ACI_LIVE_ZERO_UA));
   localparam logic [11:0] BREAK_RAW = 12'(`ACI_UA_TO_RAW(`ACI_BREAK_UA));
   localparam logic [11:0] SHORT_RAW = 12'(`ACI_UA_TO_RAW(`ACI_SHORT_UA));

   // ==========================================================
   // register read image
   function automatic logic [31:0] read_word(input aci_pkg::aci_state_type st,
                                             input logic [7:0] addr);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (addr)
         `ACI_OFF_CTRL: begin
            w[`ACI_CTRL_WSTAT] = st.with_status;
            w[`ACI_CTRL_LFD] = st.lfd_en;
            w[`ACI_CTRL_SIM] = st.sim_mode;
            w[`ACI_CTRL_EMODE_HI:`ACI_CTRL_EMODE_LO] = st.err_mode;
            w[`ACI_CTRL_DIAG] = st.diag_en;
            w[`ACI_CTRL_HART] = st.hart_en;
            w[`ACI_CTRL_HVARS_HI:`ACI_CTRL_HVARS_LO] = st.hart_vars;
         end
         `ACI_OFF_SCALE: w = {st.scale_end, st.scale_start};
         `ACI_OFF_THRESH: w = {4'h0, st.sht_thr, 4'h0, st.brk_thr};
         `ACI_OFF_SUBST: w = {16'h0000, st.subst};
         `ACI_OFF_SIM: w = {16'h0000, st.simval};
         `ACI_OFF_LIMIT: w = {st.vmax, st.vmin};
         `ACI_OFF_STATUS: begin
            w[11:0] = st.raw;
            w[12] = st.live_zero;
            w[13] = st.brk;
            w[14] = st.sht;
            w[15] = st.fault;
            w[23:16] = st.cfg_code;
            w[24] = st.mod_err;
         end
         `ACI_OFF_TLG: w = {st.value, st.tlg_word};
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   // ==========================================================
   // word-aligned register offset of a bus address
   function automatic logic [7:0] word_addr(input logic [31:0] a);
      return {a[7:2], 2'h0};
   endfunction

   // ==========================================================
   // measured value path
   aci_scaler u_scaler (
      .raw(s_q.raw),
      .range_start(s_q.scale_start),
      .range_end(s_q.scale_end),
      .vmin(s_q.vmin),
      .vmax(s_q.vmax),
      .value(scaled)
   );

   always_comb begin
      live_zero_now = (adc_data <= LIVE_ZERO_RAW);
      brk_now = (adc_data < s_q.brk_thr);
      sht_now = (adc_data > s_q.sht_thr);
      fault_now = s_q.lfd_en && (brk_now || sht_now);
      base_val = s_q.sim_mode ? s_q.simval : scaled;
      sel_val = base_val;
      if (s_q.fault) begin
         unique case (s_q.err_mode)
            `ACI_EMODE_SUBST: sel_val = s_q.subst;
            `ACI_EMODE_LAST: sel_val = s_q.last_valid;
            default: sel_val = base_val;
         endcase
      end
      default_scale = (s_q.scale_start == `ACI_RST_START) &&
                      (s_q.scale_end == `ACI_RST_END);
      if (s_q.with_status && default_scale) begin
         word = {s_q.value[15:4], 2'h0, s_q.fault, s_q.live_zero};
      end else begin
         word = s_q.value;
      end
      vars_clamped = (s_q.hart_vars > `ACI_HVARS_MAX) ? `ACI_HVARS_MAX : s_q.hart_vars;
      addr_phase = hsel && hready && htrans[1];
   end

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.conv_start = 1'b0;
      s_d.new_meas = 1'b0;
      s_d.tlg_valid = 1'b0;
      s_d.chan_err = 1'b0;
      s_d.hreadyout = 1'b1;
      s_d.hresp = 1'b0;

      // conversion pacing
      if (s_q.conv_cnt == CONV_LAST) begin
         s_d.conv_cnt = 20'h00000;
         s_d.conv_start = 1'b1;
         s_d.conv_st = aci_pkg::CONV_BUSY;
      end else begin
         s_d.conv_cnt = s_q.conv_cnt + 20'h00001;
      end
      unique case (s_q.conv_st)
         aci_pkg::CONV_WAIT: begin
         end
         aci_pkg::CONV_BUSY: begin
            if (adc_valid) begin
               s_d.raw = adc_data;
               s_d.live_zero = live_zero_now;
               s_d.brk = s_q.lfd_en && brk_now;
               s_d.sht = s_q.lfd_en && sht_now;
               s_d.fault = fault_now;
               s_d.new_meas = 1'b1;
               s_d.conv_st = aci_pkg::CONV_WAIT;
               if (fault_now && !s_q.fault) begin
                  s_d.chan_err = s_q.diag_en;
                  s_d.err_reason = {sht_now, brk_now};
                  s_d.err_slot = SLOT;
                  s_d.err_chan = CHANNEL;
                  s_d.err_is_input = 1'b1;
               end
            end
         end
      endcase

      // value and last valid capture
      s_d.value = sel_val;
      if (s_q.new_meas && !s_q.fault) begin
         s_d.last_valid = base_val;
      end
      if (!s_q.lfd_en) begin
         s_d.brk = 1'b0;
         s_d.sht = 1'b0;
         s_d.fault = 1'b0;
      end
      s_d.mod_err = s_q.diag_en && s_q.fault;
      s_d.glob_err = s_q.diag_en && s_q.fault;

      // telegram pacing
      if (s_q.send_cnt == SEND_LAST) begin
         s_d.send_cnt = 17'h00000;
         s_d.tlg_word = word;
         s_d.tlg_valid = 1'b1;
      end else begin
         s_d.send_cnt = s_q.send_cnt + 17'h00001;
      end
      s_d.cfg_code = `ACI_CFG_BASE + 8'(vars_clamped) * `ACI_CFG_STEP;

      // bus data phase: write
      if (s_q.dph_valid && s_q.dph_write) begin
         unique case (s_q.dph_addr)
            `ACI_OFF_CTRL: begin
               s_d.with_status = hwdata[`ACI_CTRL_WSTAT];
               s_d.lfd_en = hwdata[`ACI_CTRL_LFD];
               s_d.sim_mode = hwdata[`ACI_CTRL_SIM];
               s_d.err_mode = hwdata[`ACI_CTRL_EMODE_HI:`ACI_CTRL_EMODE_LO];
               s_d.diag_en = hwdata[`ACI_CTRL_DIAG];
               s_d.hart_en = hwdata[`ACI_CTRL_HART];
               s_d.hart_vars = hwdata[`ACI_CTRL_HVARS_HI:`ACI_CTRL_HVARS_LO];
            end
            `ACI_OFF_SCALE: begin
               s_d.scale_start = hwdata[15:0];
               s_d.scale_end = hwdata[31:16];
            end
            `ACI_OFF_THRESH: begin
               s_d.brk_thr = hwdata[11:0];
               s_d.sht_thr = hwdata[27:16];
            end
            `ACI_OFF_SUBST: s_d.subst = hwdata[15:0];
            `ACI_OFF_SIM: s_d.simval = hwdata[15:0];
            `ACI_OFF_LIMIT: begin
               s_d.vmin = hwdata[15:0];
               s_d.vmax = hwdata[31:16];
            end
            default: begin
            end
         endcase
      end

      // bus address phase: latch and prepare read data
      s_d.dph_valid = addr_phase;
      s_d.dph_write = addr_phase && hwrite;
      s_d.dph_addr = word_addr(haddr);
      if (addr_phase && !hwrite) begin
         s_d.hrdata = read_word(s_q, word_addr(haddr));
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.with_status <= `ACI_RST_WSTAT;
         s_q.lfd_en <= `ACI_RST_LFD;
         s_q.err_mode <= `ACI_EMODE_CURRENT;
         s_q.diag_en <= `ACI_RST_DIAG;
         s_q.hart_en <= `ACI_RST_HART;
         s_q.scale_start <= `ACI_RST_START;
         s_q.scale_end <= `ACI_RST_END;
         s_q.brk_thr <= BREAK_RAW;
         s_q.sht_thr <= SHORT_RAW;
         s_q.subst <= `ACI_RST_SUBST;
         s_q.simval <= `ACI_RST_SIM;
         s_q.vmin <= `ACI_RST_VMIN;
         s_q.vmax <= `ACI_RST_VMAX;
         s_q.conv_st <= aci_pkg::CONV_WAIT;
         s_q.cfg_code <= `ACI_CFG_BASE;
         s_q.hreadyout <= 1'b1;
         s_q.err_slot <= SLOT;
         s_q.err_chan <= CHANNEL;
         s_q.err_is_input <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   always_comb begin
      hrdata = s_q.hrdata;
      hreadyout = s_q.hreadyout;
      hresp = s_q.hresp;
      conv_start = s_q.conv_start;
      tlg_word = s_q.tlg_word;
      tlg_valid = s_q.tlg_valid;
      cfg_code = s_q.cfg_code;
      hart_en = s_q.hart_en;
      mod_err = s_q.mod_err;
      glob_err = s_q.glob_err;
      chan_err = s_q.chan_err;
      chan_err_slot = s_q.err_slot;
      chan_err_chan = s_q.err_chan;
      chan_err_is_input = s_q.err_is_input;
      chan_err_reason = s_q.err_reason;
   end

endmodule

`default_nettype wire

// [verif/aci_fe_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// front end: answers each conversion request
module aci_fe_model #(
   parameter int DELAY = 7
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic conv_start,
   input wire logic [11:0] raw_in,
   output logic adc_valid,
   output logic [11:0] adc_data
);
   int cnt;
   initial begin
      adc_valid = 1'b0;
      adc_data = 12'h000;
      cnt = 0;
   end
   always @(posedge core_clk) begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      if (!rst_n) begin
         cnt <= 0;
      end else if (conv_start) begin
         cnt <= DELAY;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (rst_n && cnt == 1) begin
         adc_valid <= 1'b1;
         adc_data <= raw_in;
      end
   end
endmodule
`default_nettype wire

// [verif/aci_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks of the input channel
module aci_top_properties #(
   parameter int unsigned CONV_CYCLES = 200,
   parameter int unsigned SEND_CYCLES = 50,
   parameter logic [3:0] CHANNEL = 4'h1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic conv_start,
   input wire logic [15:0] tlg_word,
   input wire logic tlg_valid,
   input wire logic [7:0] cfg_code,
   input wire logic mod_err,
   input wire logic glob_err,
   input wire logic chan_err,
   input wire logic [3:0] chan_err_chan,
   input wire logic chan_err_is_input,
   input wire logic [1:0] chan_err_reason
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [31:0] tc_q;
   logic [31:0] cc_q;
   logic ts_q;
   logic cs_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tc_q <= 32'h0;
         cc_q <= 32'h0;
         ts_q <= 1'b0;
         cs_q <= 1'b0;
      end else if (ce) begin
         tc_q <= tlg_valid ? 32'h1 : tc_q + 32'h1;
         cc_q <= conv_start ? 32'h1 : cc_q + 32'h1;
         ts_q <= ts_q | tlg_valid;
         cs_q <= cs_q | conv_start;
      end
   end
   tlg_period_a: assert property (tlg_valid && ts_q |-> tc_q == SEND_CYCLES)
      else $error("telegram period wrong");
   tlg_pulse_a: assert property (tlg_valid |=> !tlg_valid)
      else $error("telegram strobe too long");
   tlg_hold_a: assert property (!tlg_valid |-> $stable(tlg_word))
      else $error("telegram word changed between sends");
   conv_period_a: assert property (conv_start && cs_q |-> cc_q == CONV_CYCLES)
      else $error("conversion period wrong");
   conv_pulse_a: assert property (conv_start |=> !conv_start)
      else $error("conversion request too long");
   cfg_code_a: assert property (cfg_code inside {8'h50, 8'h52, 8'h54, 8'h56, 8'h58})
      else $error("configuration code out of set");
   err_pair_a: assert property (mod_err == glob_err)
      else $error("module and global error differ");
   chan_info_a: assert property (chan_err |-> chan_err_reason != 2'h0 && chan_err_is_input && chan_err_chan == CHANNEL)
      else $error("channel error report incomplete");
endmodule
bind aci_top aci_top_properties #(.CONV_CYCLES(CONV_CYCLES), .SEND_CYCLES(SEND_CYCLES),
   .CHANNEL(CHANNEL)) props (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
   .conv_start(conv_start), .tlg_word(tlg_word), .tlg_valid(tlg_valid), .cfg_code(cfg_code),
   .mod_err(mod_err), .glob_err(glob_err), .chan_err(chan_err), .chan_err_chan(chan_err_chan),
   .chan_err_is_input(chan_err_is_input), .chan_err_reason(chan_err_reason));
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench for the input channel
module tb_top;
   logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, conv_start, adc_valid;
   logic tlg_valid, hart_en, mod_err, glob_err, chan_err, ce, chan_err_is_input;
   logic [3:0] chan_err_chan;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, chan_err_reason;
   logic [11:0] fe_raw, adc_data;
   logic [15:0] tlg_word;
   logic [7:0] cfg_code, chan_err_slot;
   logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
   logic [31:0] rv [7] = '{32'h63, 32'hc3502710, 32'h0cd1009c, 32'h0, 32'h0, 32'hffff0000,
      32'h0};
   int miscompares = 0;
   int samples_checked = 0;
   int chan_pulses = 0;
   int frozen_hits = 0;
   aci_top #(.CONV_CYCLES(200), .SEND_CYCLES(50), .SLOT(8'h0e)) dut (.core_clk(core_clk),
      .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start), .adc_valid(adc_valid),
      .adc_data(adc_data), .tlg_word(tlg_word), .tlg_valid(tlg_valid), .cfg_code(cfg_code),
      .hart_en(hart_en), .mod_err(mod_err), .glob_err(glob_err), .chan_err(chan_err),
      .chan_err_slot(chan_err_slot), .chan_err_chan(chan_err_chan),
      .chan_err_is_input(chan_err_is_input), .chan_err_reason(chan_err_reason));
   aci_fe_model fe (.core_clk(core_clk), .rst_n(rst_n), .conv_start(conv_start),
      .raw_in(fe_raw), .adc_valid(adc_valid), .adc_data(adc_data));
   // count channel error reports
   always @(negedge core_clk) begin
      if (chan_err === 1'b1) chan_pulses++;
   end
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100) begin
         miscompares++;
         wrap_up;
      end
   endtask
   task wt(input int s);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while ((s == 0 ? conv_start : s == 1 ? adc_valid : tlg_valid) !== 1'b1 && n < 1000);
      if (n >= 1000) begin
         miscompares++;
         wrap_up;
      end
   endtask
   // capture a new sample, then take the second telegram after it
   task meas(input logic [11:0] r, input logic [15:0] e);
      fe_raw <= r;
      wt(0);
      wt(1);
      wt(2);
      wt(2);
      chk({16'h0, tlg_word}, {16'h0, e});
   endtask
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      ce = 1'b1;
      fe_raw = 12'd625;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      chk({31'h0, hresp}, 32'h0);
      chk({24'h0, cfg_code}, 32'h50);
      chk({31'h0, hart_en}, 32'h1);
      meas(12'd625, 16'h2710);
      meas(12'd3125, 16'hc350);
      meas(12'd4000, 16'hfa02);
      chk({30'h0, chan_err_reason}, 32'h2);
      chk({31'h0, mod_err}, 32'h1);
      chk({31'h0, glob_err}, 32'h1);
      chk(chan_pulses, 32'h1);
      chk({20'h0, chan_err_chan, chan_err_slot}, 32'h0000_010e);
      chk({31'h0, chan_err_is_input}, 32'h1);
      meas(12'd500, 16'h1f41);
      meas(12'd100, 16'h0643);
      chk({30'h0, chan_err_reason}, 32'h1);
      bus(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h06400643);
      bus(1'b1, 8'h0c, 32'h1234);
      bus(1'b1, 8'h00, 32'h6b);
      meas(12'd100, 16'h1233);
      bus(1'b1, 8'h00, 32'h73);
      meas(12'd1000, 16'h3e80);
      meas(12'd100, 16'h3e83);
      bus(1'b1, 8'h00, 32'h61);
      meas(12'd100, 16'h0641);
      chk({31'h0, mod_err}, 32'h0);
      bus(1'b1, 8'h10, 32'habcd);
      bus(1'b1, 8'h00, 32'h67);
      meas(12'd1000, 16'habc0);
      bus(1'b1, 8'h00, 32'h61);
      bus(1'b1, 8'h04, 32'hc3500001);
      meas(12'd1000, 16'h1d4c);
      meas(12'd4095, 16'hffff);
      bus(1'b1, 8'h14, 32'h80000000);
      meas(12'd4095, 16'h8000);
      chk(chan_pulses, 32'h3);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, 8'h00, {21'h0, k[2:0], 8'h63});
         repeat (2) @(negedge core_clk);
         chk({24'h0, cfg_code}, 32'h50 + 2 * (k > 4 ? 4 : k));
      end
      bus(1'b1, 8'h00, 32'h23);
      repeat (2) @(negedge core_clk);
      chk({31'h0, hart_en}, 32'h0);
      // freeze the channel right after a telegram, then let it resume
      wt(2);
      @(posedge core_clk);
      ce <= 1'b0;
      repeat (120) begin
         @(negedge core_clk);
         if (tlg_valid === 1'b1 || conv_start === 1'b1) frozen_hits++;
      end
      chk(frozen_hits, 32'h0);
      @(posedge core_clk);
      ce <= 1'b1;
      wt(2);
      wrap_up;
   end
endmodule
`default_nettype wire
